// file: rtl/input_check_top.sv
`timescale 1ns/10ps
// Overview of operation
// - Pattern test runs and mutes analog outputs
// - Alarms clear after 64 good samples
// - Sense bit picks even or odd parity
// - Word parity checks against parity lane bit
// - Frame parity takes bit from frame signal
// - I complement bit inverts I data
// - Q complement bit inverts Q data
// - Two-apart enable raises FIFO proximity alarm
// - One-apart enable raises FIFO proximity alarm
// - Collision enable raises FIFO collision alarm
// - Control register resets to 0x050e
module input_check_top
    import input_check_pkg::*;
#(
    parameter int          PTR_W     = $clog2(FIFO_DEPTH), // FIFO pointer width
    parameter logic [15:0] PATTERN_I = 16'h00ff,           // Expected I test word
    parameter logic [15:0] PATTERN_Q = 16'hff00            // Expected Q test word
) (
    input  wire logic               clk_sys_in,
    input  wire logic               rst_in,
    input  wire reg_req_t           reg_req_in,        // Configuration write
    output logic      [15:0]        reg_rdata_out,     // Read data at reg_req_in.addr
    input  wire sample_t            sample_pins_in,    // Data bus pins
    input  wire logic               tx_enable_in,      // Transmit enable pin
    input  wire logic               sif_tx_enable_in,  // Serial transmit enable bit
    input  wire logic [PTR_W-1:0]   fifo_wr_ptr_in,    // FIFO write pointer
    input  wire logic [PTR_W-1:0]   fifo_rd_ptr_in,    // FIFO read pointer
    input  wire logic               alarm_clear_in,    // Software alarm clear pulse
    output logic      [15:0]        i_channel_output_out,
    output logic      [15:0]        q_channel_output_out,
    output logic                    outputs_active_out, // Analog outputs enabled
    output logic      [ALARM_W-1:0] alarms_out
);

    // Shortest circular distance between two FIFO pointers
    function automatic logic [PTR_W-1:0] ptr_gap(input logic [PTR_W-1:0] a,
                                                 input logic [PTR_W-1:0] b);
        logic [PTR_W-1:0] d;
        d = a - b;
        ptr_gap = (d > PTR_W'(FIFO_DEPTH / 2)) ? PTR_W'(-d) : d;
    endfunction : ptr_gap

    logic [15:0]        ctrl_r, ctrl_nxt;      // input_check_control
    logic [15:0]        rdata_r, rdata_nxt;    // Registered read data
    sample_t            s1_r, s2_r;            // Pin synchroniser stages
    logic               txen_s1_r, txen_s2_r;  // Transmit enable pin synchroniser
    logic [15:0]        i_r, i_nxt;            // I output word
    logic [15:0]        q_r, q_nxt;            // Q output word
    logic               active_r, active_nxt;  // Output enable
    logic [ALARM_W-1:0] events;                // Error events this cycle
    logic               good;                  // Valid error-free sample
    logic               par_bit;               // Parity bit in use
    logic               par_check;             // Parity checking on
    logic [PTR_W-1:0]   gap;                   // Pointer distance
    logic               test_on;               // Pattern checker running

    // Control register next value; reserved bits are stored as written
    always_comb begin
        ctrl_nxt = ctrl_r;
        if (reg_req_in.wr && reg_req_in.addr == CTRL_ADDR) begin
            ctrl_nxt = reg_req_in.wdata;
        end
        // Unmapped offsets read as zero
        rdata_nxt = (reg_req_in.addr == CTRL_ADDR) ? ctrl_r : 16'h0000;
    end

    // Control registers
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            ctrl_r  <= CTRL_RESET;
            rdata_r <= 16'h0000;
        end else begin
            ctrl_r  <= ctrl_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // Pins come from the bus source's domain, so two stages before use
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            s1_r      <= '0;
            s2_r      <= '0;
            txen_s1_r <= 1'b0;
            txen_s2_r <= 1'b0;
        end else begin
            s1_r      <= sample_pins_in;
            s2_r      <= s1_r;
            txen_s1_r <= tx_enable_in;
            txen_s2_r <= txen_s1_r;
        end
    end

    // Error detection on the synchronised sample
    always_comb begin
        test_on   = ctrl_r[PATTERN_TEST_B];
        // Frame source takes priority when both parity sources are enabled
        par_bit   = ctrl_r[FRAME_PARITY_B] ? s2_r.frame : s2_r.parity_lane;
        par_check = ctrl_r[FRAME_PARITY_B] || ctrl_r[WORD_PARITY_B];
        gap       = ptr_gap(fifo_wr_ptr_in, fifo_rd_ptr_in);
        events    = '0;
        events[ALM_PARITY] = s2_r.valid && par_check &&
            !parity_ok({s2_r.i, s2_r.q}, par_bit, ctrl_r[ODD_PARITY_B]);
        events[ALM_PATTERN] = s2_r.valid && test_on &&
            (s2_r.i != PATTERN_I || s2_r.q != PATTERN_Q);
        events[ALM_COLLIDE]   = ctrl_r[COLLIDE_B] && gap == PTR_W'(0);
        events[ALM_ONE_APART] = ctrl_r[ONE_APART_B] && gap == PTR_W'(1);
        events[ALM_TWO_APART] = ctrl_r[TWO_APART_B] && gap == PTR_W'(2);
        good = s2_r.valid && !(|events);
    end

    // Output data path; test mode forces the converter side quiet
    always_comb begin
        i_nxt      = i_r;
        q_nxt      = q_r;
        active_nxt = txen_s2_r && sif_tx_enable_in && !test_on;
        if (test_on) begin
            i_nxt = 16'h0000;
            q_nxt = 16'h0000;
        end else if (s2_r.valid) begin
            i_nxt = ctrl_r[I_INVERT_B] ? ~s2_r.i : s2_r.i;
            q_nxt = ctrl_r[Q_INVERT_B] ? ~s2_r.q : s2_r.q;
        end
    end

    // Output registers
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            i_r      <= 16'h0000;
            q_r      <= 16'h0000;
            active_r <= 1'b0;
        end else begin
            i_r      <= i_nxt;
            q_r      <= q_nxt;
            active_r <= active_nxt;
        end
    end

    // Sticky alarms with the good-run auto clear
    good_run_alarms #(
        .RUN_LEN         (GOOD_RUN_LEN)
    ) u_alarms (
        .clk_sys_in      (clk_sys_in),
        .rst_in          (rst_in),
        .events_in       (events),
        .good_in         (good),
        .autoclear_en_in (ctrl_r[GOOD_RUN_B]),
        .sw_clear_in     (alarm_clear_in),
        .alarms_out      (alarms_out)
    );

    assign reg_rdata_out        = rdata_r;
    assign i_channel_output_out = i_r;
    assign q_channel_output_out = q_r;
    assign outputs_active_out   = active_r;

    // Helper: set once software has written the control register
    logic wrote_r;
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            wrote_r <= 1'b0;
        end else if (reg_req_in.wr && reg_req_in.addr == CTRL_ADDR) begin
            wrote_r <= 1'b1;
        end
    end

    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);

    ctrl_reset_a: assert property (!wrote_r |-> ctrl_r == 16'h050e)
        else $error("Control register lost its reset value");
    test_mute_a: assert property (ctrl_r[PATTERN_TEST_B] |=>
        !outputs_active_out && i_channel_output_out == 16'h0000)
        else $error("Outputs active during pattern test");
    i_invert_a: assert property (s2_r.valid && !test_on && ctrl_r[I_INVERT_B] |=>
        i_channel_output_out == ~$past(s2_r.i))
        else $error("I data not inverted");
    q_invert_a: assert property (s2_r.valid && !test_on && !ctrl_r[Q_INVERT_B] |=>
        q_channel_output_out == $past(s2_r.q))
        else $error("Q data changed without invert");
    word_parity_a: assert property (s2_r.valid && ctrl_r[WORD_PARITY_B] &&
        !ctrl_r[FRAME_PARITY_B] &&
        ((^{s2_r.i, s2_r.q, s2_r.parity_lane}) != ctrl_r[ODD_PARITY_B])
        |=> alarms_out[ALM_PARITY])
        else $error("Word parity error missed");
    frame_parity_a: assert property (s2_r.valid && ctrl_r[FRAME_PARITY_B] &&
        ((^{s2_r.i, s2_r.q, s2_r.frame}) != ctrl_r[ODD_PARITY_B])
        |=> alarms_out[ALM_PARITY])
        else $error("Frame parity error missed");
    parity_sense_a: assert property (events[ALM_PARITY] |->
        (^{s2_r.i, s2_r.q, par_bit}) == !ctrl_r[ODD_PARITY_B])
        else $error("Parity flagged with wrong sense");
    collide_a: assert property (ctrl_r[COLLIDE_B] &&
        fifo_wr_ptr_in == fifo_rd_ptr_in |=> alarms_out[ALM_COLLIDE])
        else $error("Collision alarm missed");
    one_apart_a: assert property (ctrl_r[ONE_APART_B] &&
        PTR_W'(fifo_wr_ptr_in + PTR_W'(1)) == fifo_rd_ptr_in |=> alarms_out[ALM_ONE_APART])
        else $error("One-apart alarm missed");
    two_apart_a: assert property (ctrl_r[TWO_APART_B] &&
        PTR_W'(fifo_rd_ptr_in + PTR_W'(2)) == fifo_wr_ptr_in |=> alarms_out[ALM_TWO_APART])
        else $error("Two-apart alarm missed");

    parity_hit_c: cover property (events[ALM_PARITY]);
    test_run_c:   cover property (test_on && s2_r.valid && !events[ALM_PATTERN]);
    inverted_c:   cover property (ctrl_r[I_INVERT_B] && ctrl_r[Q_INVERT_B] && s2_r.valid);

endmodule : input_check_top

// file: rtl/input_check_pkg.sv
package input_check_pkg;

    // Register map
    localparam logic [6:0]  CTRL_ADDR       = 7'h01;   // Offset of input_check_control
    localparam logic [15:0] CTRL_RESET      = 16'h050e; // Value after reset

    // Field positions in input_check_control
    localparam int          PATTERN_TEST_B  = 15;      // Pattern checker enable
    localparam int          GOOD_RUN_B      = 12;      // good_run_autoclear_enable
    localparam int          ODD_PARITY_B    = 11;      // 0 even, 1 odd
    localparam int          WORD_PARITY_B   = 10;      // Check against parity_lane
    localparam int          FRAME_PARITY_B  = 9;       // Check against the frame signal
    localparam int          I_INVERT_B      = 6;       // i_channel_invert
    localparam int          Q_INVERT_B      = 5;       // q_channel_invert
    localparam int          TWO_APART_B     = 3;       // fifo_two_apart_alarm_enable
    localparam int          ONE_APART_B     = 2;       // fifo_one_apart_alarm_enable
    localparam int          COLLIDE_B       = 1;       // FIFO collision alarm enable

    // Alarm vector layout
    localparam int          ALARM_W         = 5;
    localparam int          ALM_PATTERN     = 4;
    localparam int          ALM_PARITY      = 3;
    localparam int          ALM_COLLIDE     = 2;
    localparam int          ALM_ONE_APART   = 1;
    localparam int          ALM_TWO_APART   = 0;

    // Timing counts
    localparam int          GOOD_RUN_LEN    = 64;      // Good samples before auto clear
    localparam int          FIFO_DEPTH      = 8;       // Samples in the input FIFO

    // One sample as it arrives on the data bus pins
    typedef struct packed {
        logic [15:0] i;            // I-channel word
        logic [15:0] q;            // Q-channel word
        logic        parity_lane;  // Per-word parity bit
        logic        frame;        // Frame signal
        logic        valid;        // Sample strobe
    } sample_t;

    // Serial configuration access, already deserialised
    typedef struct packed {
        logic        wr;           // One-cycle write strobe
        logic [6:0]  addr;         // Register offset
        logic [15:0] wdata;        // Write data
    } reg_req_t;

    // True when data and parity bit carry the selected sense
    function automatic logic parity_ok(input logic [31:0] data, input logic par_bit,
                                       input logic odd);
        parity_ok = ((^data) ^ par_bit) == odd;
    endfunction : parity_ok

endpackage : input_check_pkg

// file: rtl/good_run_alarms.sv
`timescale 1ns/10ps
// Sticky alarm bits with optional clearing after an unbroken run of good samples
module good_run_alarms
    import input_check_pkg::*;
#(
    parameter int RUN_LEN = GOOD_RUN_LEN
) (
    input  wire logic               clk_sys_in,
    input  wire logic               rst_in,
    input  wire logic [ALARM_W-1:0] events_in,      // Error events this cycle
    input  wire logic               good_in,        // Valid sample with no error
    input  wire logic               autoclear_en_in,
    input  wire logic               sw_clear_in,    // Software clear pulse
    output logic      [ALARM_W-1:0] alarms_out
);
    localparam int CNT_W = $clog2(RUN_LEN + 1);

    logic [CNT_W-1:0]   cnt_r, cnt_nxt;        // Good samples seen in a row
    logic [ALARM_W-1:0] alarms_r, alarms_nxt;  // Sticky alarms
    logic               bad;                   // Any error this cycle
    logic               autoclear;             // Run complete

    // Counter and alarm next state
    always_comb begin
        bad       = |events_in;
        autoclear = 1'b0;
        cnt_nxt   = cnt_r;
        if (!autoclear_en_in || bad) begin
            // An error breaks the run, so counting starts over
            cnt_nxt = '0;
        end else if (good_in) begin
            if (cnt_r == CNT_W'(RUN_LEN - 1)) begin
                autoclear = 1'b1;
                cnt_nxt   = '0;
            end else begin
                cnt_nxt = cnt_r + CNT_W'(1);
            end
        end
        // New events win over any clear in the same cycle
        alarms_nxt = ((autoclear || sw_clear_in) ? '0 : alarms_r) | events_in;
    end

    // State registers
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            cnt_r    <= '0;
            alarms_r <= '0;
        end else begin
            cnt_r    <= cnt_nxt;
            alarms_r <= alarms_nxt;
        end
    end

    assign alarms_out = alarms_r;

    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);

    run_clear_a: assert property (autoclear && !sw_clear_in |=>
        alarms_r == $past(events_in))
        else $error("Alarms not cleared after good run");
    run_restart_a: assert property (bad |=> cnt_r == '0)
        else $error("Good run counter did not restart on error");
    run_hold_a: assert property (!autoclear && !sw_clear_in |=>
        (alarms_r & $past(alarms_r)) == $past(alarms_r))
        else $error("Alarm dropped without a clear");
    run_done_c: cover property (autoclear && alarms_r != '0);

endmodule : good_run_alarms

// file: sim/sample_source.sv
`timescale 1ns/10ps
// Host logic on the far side of the data bus: one sample a cycle, then release
module sample_source
    import input_check_pkg::*;
(
    input  wire logic clk_sys_in,
    output sample_t   pins_out    // Data bus pins into the block
);
    // Bus starts released
    initial pins_out = '0;

    // Present one sample at a falling edge and hold it until the next one
    task automatic send(input logic [15:0] i, input logic [15:0] q,
                        input logic par, input logic frm);
        pins_out = '{i: i, q: q, parity_lane: par, frame: frm, valid: 1'b1};
        @(negedge clk_sys_in);
    endtask : send

    // Released bus shows inverted data so a stale word never looks fresh
    task automatic idle();
        pins_out = '{i: ~pins_out.i, q: ~pins_out.q, parity_lane: ~pins_out.parity_lane,
                     frame: ~pins_out.frame, valid: 1'b0};
    endtask : idle
endmodule : sample_source

// file: sim/tb_top.sv
`timescale 1ns/10ps
// Register and sample-path tests for the input check block
module tb_top;
    import input_check_pkg::*;
    logic               clk_sys_in;
    logic               rst_in;
    logic               tx_enable_in;
    logic               sif_tx_enable_in;
    logic               alarm_clear_in;
    reg_req_t           reg_req_in;      // Configuration access
    sample_t            pins;            // Driven by the host model
    logic [2:0]         wr_ptr;
    logic [2:0]         rd_ptr;
    logic [15:0]        rdata;
    logic [15:0]        i_out;
    logic [15:0]        q_out;
    logic [15:0]        got;
    logic               active;
    logic [ALARM_W-1:0] alarms;
    logic [31:0]        w;
    logic               p;
    int                 num_errors = 0;
    int                 checks = 0;
    int                 cycles = 0;

    // Test words handed to the design, so both sides expect the same pattern
    localparam logic [15:0] PATTERN_I = 16'h00ff;
    localparam logic [15:0] PATTERN_Q = 16'hff00;

    input_check_top #(.PTR_W(3), .PATTERN_I(PATTERN_I), .PATTERN_Q(PATTERN_Q)) dut_u (
        .clk_sys_in(clk_sys_in), .rst_in(rst_in),
        .reg_req_in(reg_req_in), .reg_rdata_out(rdata), .sample_pins_in(pins),
        .tx_enable_in(tx_enable_in), .sif_tx_enable_in(sif_tx_enable_in),
        .fifo_wr_ptr_in(wr_ptr), .fifo_rd_ptr_in(rd_ptr), .alarm_clear_in(alarm_clear_in),
        .i_channel_output_out(i_out), .q_channel_output_out(q_out),
        .outputs_active_out(active), .alarms_out(alarms));
    sample_source src_u (.clk_sys_in(clk_sys_in), .pins_out(pins));

    // Free-running 100 MHz clock
    initial begin
        clk_sys_in = 1'b0;
        forever #5 clk_sys_in = ~clk_sys_in;
    end

    // Cut a hang short; the tests need well under a thousand cycles
    always @(posedge clk_sys_in) begin
        cycles++;
        if (cycles == 5000) begin
            num_errors++;
            stop_test();
        end
    end

    // Compare and report
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // One-cycle write strobe, taken at the rising edge
    task automatic wr(input logic [6:0] addr, input logic [15:0] data);
        reg_req_in = '{wr: 1'b1, addr: addr, wdata: data};
        @(negedge clk_sys_in);
        reg_req_in.wr = 1'b0;
        @(negedge clk_sys_in);
    endtask : wr

    // Read data is registered, so wait two edges after the address settles
    task automatic rd(input logic [6:0] addr, output logic [15:0] data);
        reg_req_in.addr = addr;
        repeat (2) @(negedge clk_sys_in);
        data = rdata;
    endtask : rd

    // Software alarm clear pulse
    task automatic clr();
        alarm_clear_in = 1'b1;
        @(negedge clk_sys_in);
        alarm_clear_in = 1'b0;
    endtask : clr

    // Single sample, then wait out the two sync stages and the output register
    task automatic smp(input logic [15:0] i, input logic [15:0] q, input logic par,
                       input logic frm);
        src_u.send(i, q, par, frm);
        src_u.idle();
        repeat (4) @(negedge clk_sys_in);
    endtask : smp

    // Back-to-back good samples under even parity
    task automatic burst(input int n);
        for (int k = 0; k < n; k++) begin
            src_u.send(16'(k + 2), 16'h0, ^16'(k + 2), 1'b0);
        end
    endtask : burst

    // Verdict and end of run
    task automatic stop_test();
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : stop_test

    // Main sequence
    initial begin
        rst_in = 1'b1;
        reg_req_in = '0;
        tx_enable_in = 1'b1;
        sif_tx_enable_in = 1'b1;
        alarm_clear_in = 1'b0;
        wr_ptr = 3'h4;
        rd_ptr = 3'h0;
        repeat (5) @(negedge clk_sys_in);
        rst_in = 1'b0;
        rd(CTRL_ADDR, got);
        chk("ctrl reset", CTRL_RESET, got);
        chk("alarms reset", 16'h0000, 16'(alarms));
        rd(7'h02, got);
        chk("unmapped read", 16'h0000, got);
        wr(CTRL_ADDR, 16'h0406);
        wr(7'h02, 16'hffff);
        rd(CTRL_ADDR, got);
        chk("ctrl write", 16'h0406, got);
        $display("test registers done");
        // Each sense with each source: right bit on the chosen source only
        for (int k = 0; k < 4; k++) begin
            wr(CTRL_ADDR, {4'h0, k[0], 1'b1, k[1], 9'h00e});
            w = 32'h1234_00f1 + 32'(k);
            p = (^w) ^ k[0];
            clr();
            smp(w[31:16], w[15:0], k[1] ? ~p : p, k[1] ? p : ~p);
            chk("parity good", 16'h0000, 16'(alarms[ALM_PARITY]));
            chk("i data", w[31:16], i_out);
            smp(w[31:16], w[15:0], k[1] ? p : ~p, k[1] ? ~p : p);
            chk("parity bad", 16'h0001, 16'(alarms[ALM_PARITY]));
        end
        $display("test parity done");
        wr(CTRL_ADDR, 16'h0466);
        smp(16'h1357, 16'h2468, 1'b0, 1'b0);
        chk("i invert", ~16'h1357, i_out);
        chk("q invert", ~16'h2468, q_out);
        wr(CTRL_ADDR, 16'h0446);
        smp(16'h1357, 16'h2468, 1'b0, 1'b0);
        chk("i only invert", ~16'h1357, i_out);
        chk("q plain", 16'h2468, q_out);
        $display("test invert done");
        // Pattern test mutes the outputs although both enables are high
        wr(CTRL_ADDR, 16'h8406);
        clr();
        smp(PATTERN_I, PATTERN_Q, 1'b0, 1'b0);
        chk("pattern active", 16'h0000, 16'(active));
        chk("pattern ok", 16'h0000, 16'(alarms[ALM_PATTERN]));
        smp(PATTERN_I ^ 16'h0001, PATTERN_Q, 1'b0, 1'b0);
        chk("pattern bad", 16'h0001, 16'(alarms[ALM_PATTERN]));
        wr(CTRL_ADDR, 16'h0406);
        repeat (4) @(negedge clk_sys_in);
        chk("active again", 16'h0001, 16'(active));
        $display("test pattern done");
        // Pointer gaps 0, 1, 2 across the wrap point, disabled then enabled
        for (int g = 0; g < 3; g++) begin
            wr(CTRL_ADDR, 16'h0400);
            wr_ptr = 3'h7;
            rd_ptr = 3'(7 + g);
            clr();
            repeat (3) @(negedge clk_sys_in);
            chk("fifo masked", 16'h0000, 16'(alarms));
            wr(CTRL_ADDR, 16'h0400 | (16'h0002 << g));
            repeat (2) @(negedge clk_sys_in);
            chk("fifo alarm", 16'h0001 << (2 - g), 16'(alarms));
            wr_ptr = 3'h4;
            rd_ptr = 3'h0;
        end
        $display("test fifo done");
        // An error inside the run restarts the count
        wr(CTRL_ADDR, 16'h1406);
        clr();
        src_u.send(16'h0001, 16'h0, 1'b0, 1'b0);
        burst(30);
        src_u.send(16'h0001, 16'h0, 1'b0, 1'b0);
        burst(63);
        src_u.idle();
        repeat (4) @(negedge clk_sys_in);
        chk("run broken", 16'h0001, 16'(alarms[ALM_PARITY]));
        src_u.send(16'h0001, 16'h0, 1'b0, 1'b0);
        burst(64);
        src_u.idle();
        repeat (4) @(negedge clk_sys_in);
        chk("auto clear", 16'h0000, 16'(alarms));
        $display("test autoclear done");
        stop_test();
    end
endmodule : tb_top
